// [rtl/mdp_pkg.sv]
package mdp_pkg;

   // bus geometry
   localparam int ADDR_W = 10;
   localparam int DATA_W = 32;

   // register indices; byte address is four times the index
   localparam logic [7:0] TWO_PH_IDX   = 8'h96;
   localparam logic [7:0] THREE_PH_IDX = 8'h98;
   localparam logic [ADDR_W-1:0] TWO_PH_ADDR   = {TWO_PH_IDX, 2'h0};
   localparam logic [ADDR_W-1:0] THREE_PH_ADDR = {THREE_PH_IDX, 2'h0};
   localparam logic [DATA_W-1:0] PROFILE_RESET = 32'h0000_0000;
   localparam logic [DATA_W-1:0] UNMAPPED_READ = 32'h0000_0000;

   // field layout
   localparam int PARITY_BIT   = 31;
   localparam int STEP_W       = 3;
   localparam int NUM_STEPS    = 8;
   localparam int STEP0_MSB    = 30;
   localparam int STEP7_LSB    = 7;
   localparam int ANGLE_LSB    = 5;
   localparam int ANGLE_W      = 2;
   localparam int TWO_RSVD_W   = 7;
   localparam int THREE_RSVD_W = 5;

   // duty in hundredths of a percent
   localparam int DUTY_W = 14;
   localparam logic [DUTY_W-1:0] DUTY_CODE0 = 14'h0000;
   localparam logic [DUTY_W-1:0] DUTY_CODE1 = 14'h1388;
   localparam logic [DUTY_W-1:0] DUTY_CODE2 = 14'h1D4C;
   localparam logic [DUTY_W-1:0] DUTY_CODE3 = 14'h20B7;
   localparam logic [DUTY_W-1:0] DUTY_CODE4 = 14'h222E;
   localparam logic [DUTY_W-1:0] DUTY_CODE5 = 14'h249F;
   localparam logic [DUTY_W-1:0] DUTY_CODE6 = 14'h2616;
   localparam logic [DUTY_W-1:0] DUTY_CODE7 = 14'h26AC;

   // lead angle advance, electrical degrees per code step
   localparam int ANGLE_DEG_W = 4;
   localparam logic [ANGLE_DEG_W-1:0] ANGLE_STEP_DEG = 4'h5;

   typedef logic [STEP_W-1:0] mdp_step_type;

   typedef struct packed {
      logic                        parity;
      mdp_step_type [0:NUM_STEPS-1] steps;
      logic [TWO_RSVD_W-1:0]       reserved;
   } mdp_two_profile_type;

   typedef struct packed {
      logic                        parity;
      mdp_step_type [0:NUM_STEPS-1] steps;
      logic [ANGLE_W-1:0]          angle_advance;
      logic [THREE_RSVD_W-1:0]     reserved;
   } mdp_three_profile_type;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } mdp_bus_req_type;

   typedef struct packed {
      mdp_step_type      code;
      logic [DUTY_W-1:0] duty;
   } mdp_duty_type;

   // true when an access hits the given register address
   function automatic logic mdp_hit(input logic [ADDR_W-1:0] addr,
                                    input logic [ADDR_W-1:0] target);
      mdp_hit = (addr == target);
   endfunction

endpackage

// [rtl/mdp_profile_word.sv]
`timescale 1ns/1ps

// one read/write profile word; every bit is stored, reserved ones too
module mdp_profile_word
   import mdp_pkg::*;
(
   input  wire logic              clk_sys_in,
   input  wire logic              reset_in,
   input  wire logic              clk_en_in,
   input  wire logic              wr_en_in,
   input  wire logic [DATA_W-1:0] wr_data_in,
   output logic      [DATA_W-1:0] word_out
);

   logic [DATA_W-1:0] next_word;

   // whole-word write, no byte lanes on this port
   assign next_word = wr_en_in ? wr_data_in : word_out;

   // reset to the documented zero value
   always_ff @(posedge clk_sys_in or posedge reset_in)
   begin
      if (reset_in)
         word_out <= PROFILE_RESET;
      else if (clk_en_in)
         word_out <= next_word;
   end

endmodule

// [rtl/mdp_duty_decode.sv]
`timescale 1ns/1ps

// registered map from a 3-bit step code to its duty figure
module mdp_duty_decode
   import mdp_pkg::*;
(
   input  wire logic         clk_sys_in,
   input  wire logic         reset_in,
   input  wire logic         clk_en_in,
   input  wire mdp_step_type code_in,
   output mdp_duty_type      duty_out
);

   logic [DUTY_W-1:0] table_duty;
   mdp_duty_type      next_duty;

   // eight-level duty table
   always_comb
   begin
      unique case (code_in)
         3'h0: table_duty = DUTY_CODE0;
         3'h1: table_duty = DUTY_CODE1;
         3'h2: table_duty = DUTY_CODE2;
         3'h3: table_duty = DUTY_CODE3;
         3'h4: table_duty = DUTY_CODE4;
         3'h5: table_duty = DUTY_CODE5;
         3'h6: table_duty = DUTY_CODE6;
         3'h7: table_duty = DUTY_CODE7;
      endcase
   end

   assign next_duty = '{code: code_in, duty: table_duty};

   // output flop so the consumer sees a clean value
   always_ff @(posedge clk_sys_in or posedge reset_in)
   begin
      if (reset_in)
         duty_out <= '0;
      else if (clk_en_in)
         duty_out <= next_duty;
   end

endmodule

// [rtl/mdp_profile_regs.sv]
// Functional notes
// - two-phase profile word at 0x96, resets zero
// - eight two-phase step fields, bits 30 down to 7
// - step code selects one of eight duties
// - two-phase bits 6-0 stored, no effect
// - three-phase profile word at 0x98, resets zero
// - three-phase steps 0-2 at bits 30-22
// - two-phase word drives two-phase intervals, three likewise
// - three-phase steps 3-7 bits 21-7, 4-0 reserved
// - three-phase bits 6-5 select 0/5/10/15 degree advance
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps

module mdp_profile_regs
   import mdp_pkg::*;
(
   input  wire logic                   clk_sys_in,
   input  wire logic                   reset_in,
   input  wire logic                   clk_en_in,
   input  wire logic [ADDR_W-1:0]      addr_in,
   input  wire logic [DATA_W-1:0]      wr_data_in,
   input  wire logic                   wr_strobe_in,
   input  wire logic                   rd_strobe_in,
   output logic      [DATA_W-1:0]      rd_data_out,
   input  wire logic                   two_phase_interval_in,
   input  wire mdp_step_type           step_sel_in,
   output mdp_two_profile_type         two_phase_profile_out,
   output mdp_three_profile_type       three_phase_profile_out,
   output mdp_duty_type                two_phase_duty_out,
   output mdp_duty_type                three_phase_duty_out,
   output mdp_duty_type                applied_duty_out,
   output logic      [ANGLE_DEG_W-1:0] angle_advance_deg_out
);

   // bus request carried as one bundle
   mdp_bus_req_type bus_req;

   assign bus_req = '{addr: addr_in,
                      wdata: wr_data_in,
                      wr: wr_strobe_in,
                      rd: rd_strobe_in};

   // address decode, shared by the write and read paths
   logic hit_two;
   logic hit_three;
   logic wr_two;
   logic wr_three;
   logic rd_hit;

   assign hit_two   = mdp_hit(bus_req.addr, TWO_PH_ADDR);
   assign hit_three = mdp_hit(bus_req.addr, THREE_PH_ADDR);
   assign wr_two    = bus_req.wr && hit_two;
   assign wr_three  = bus_req.wr && hit_three;
   assign rd_hit    = hit_two || hit_three;

   // storage; writes to any other address are dropped silently
   logic [DATA_W-1:0] word_two;
   logic [DATA_W-1:0] word_three;
   logic [1:0]        wr_en_vec;
   logic [DATA_W-1:0] word_vec [0:1];

   assign wr_en_vec = {wr_three, wr_two};

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++)
      begin : g_word
         // full 32 bits kept, parity and reserved bits included
         mdp_profile_word u_word (
            .clk_sys_in (clk_sys_in),
            .reset_in   (reset_in),
            .clk_en_in  (clk_en_in),
            .wr_en_in   (wr_en_vec[gi]),
            .wr_data_in (bus_req.wdata),
            .word_out   (word_vec[gi])
         );
      end
   endgenerate

   assign word_two   = word_vec[0];
   assign word_three = word_vec[1];

   // field views of the stored words
   mdp_two_profile_type   view_two;
   mdp_three_profile_type view_three;

   assign view_two   = mdp_two_profile_type'(word_two);
   assign view_three = mdp_three_profile_type'(word_three);

   // read path: data stands in the cycle after the strobe only
   logic [DATA_W-1:0] read_mux;
   logic [DATA_W-1:0] next_rd_data;

   assign read_mux = hit_two   ? word_two :
                     hit_three ? word_three :
                                 UNMAPPED_READ;

   assign next_rd_data = (bus_req.rd && rd_hit) ? read_mux : UNMAPPED_READ;

   always_ff @(posedge clk_sys_in or posedge reset_in)
   begin
      if (reset_in)
         rd_data_out <= '0;
      else if (clk_en_in)
         rd_data_out <= next_rd_data;
   end

   // mirror the words to the commutation engine from flops
   always_ff @(posedge clk_sys_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         two_phase_profile_out   <= '0;
         three_phase_profile_out <= '0;
      end
      else if (clk_en_in)
      begin
         two_phase_profile_out   <= view_two;
         three_phase_profile_out <= view_three;
      end
   end

   // step selection for the step the engine is in
   mdp_step_type sel_two;
   mdp_step_type sel_three;
   mdp_step_type sel_applied;

   assign sel_two   = view_two.steps[step_sel_in];
   assign sel_three = view_three.steps[step_sel_in];

   // interval kind picks which word supplies the duty
   assign sel_applied = two_phase_interval_in ? sel_two : sel_three;

   // three duty decoders: both candidates plus the applied one;
   // a separate applied decoder keeps its output a single flop stage
   mdp_step_type dec_code [0:2];
   mdp_duty_type dec_duty [0:2];

   assign dec_code[0] = sel_two;
   assign dec_code[1] = sel_three;
   assign dec_code[2] = sel_applied;

   generate
      for (gi = 0; gi < 3; gi++)
      begin : g_dec
         mdp_duty_decode u_dec (
            .clk_sys_in (clk_sys_in),
            .reset_in   (reset_in),
            .clk_en_in  (clk_en_in),
            .code_in    (dec_code[gi]),
            .duty_out   (dec_duty[gi])
         );
      end
   endgenerate

   assign two_phase_duty_out   = dec_duty[0];
   assign three_phase_duty_out = dec_duty[1];
   assign applied_duty_out     = dec_duty[2];

   // lead angle: code times five degrees, 0 to 15
   logic [ANGLE_DEG_W-1:0] angle_ext;
   logic [ANGLE_DEG_W-1:0] next_angle;

   assign angle_ext  = {{(ANGLE_DEG_W-ANGLE_W){1'b0}}, view_three.angle_advance};
   assign next_angle = ANGLE_DEG_W'(angle_ext * ANGLE_STEP_DEG);

   always_ff @(posedge clk_sys_in or posedge reset_in)
   begin
      if (reset_in)
         angle_advance_deg_out <= '0;
      else if (clk_en_in)
         angle_advance_deg_out <= next_angle;
   end

endmodule

// [verif/mdp_profile_regs_props.sv]
`timescale 1ns/1ps

module mdp_profile_regs_props
   import mdp_pkg::*;
(
   input wire logic                   clk_sys_in,
   input wire logic                   reset_in,
   input wire logic                   clk_en_in,
   input wire logic [ADDR_W-1:0]      addr_in,
   input wire logic [DATA_W-1:0]      wr_data_in,
   input wire logic                   wr_strobe_in,
   input wire logic                   rd_strobe_in,
   input wire logic [DATA_W-1:0]      rd_data_out,
   input wire logic                   two_phase_interval_in,
   input wire mdp_step_type           step_sel_in,
   input wire mdp_two_profile_type    two_phase_profile_out,
   input wire mdp_three_profile_type  three_phase_profile_out,
   input wire mdp_duty_type           two_phase_duty_out,
   input wire mdp_duty_type           three_phase_duty_out,
   input wire mdp_duty_type           applied_duty_out,
   input wire logic [ANGLE_DEG_W-1:0] angle_advance_deg_out
);
   // duty per code in hundredths of a percent, kept apart from the design's table
   localparam logic [13:0] DT [8] = '{14'h0000, 14'h1388, 14'h1D4C, 14'h20B7,
                                      14'h222E, 14'h249F, 14'h2616, 14'h26AC};
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (reset_in);
   wire hit2 = (addr_in == TWO_PH_ADDR);
   wire hit3 = (addr_in == THREE_PH_ADDR);

   property p_rd_two; clk_en_in && rd_strobe_in && hit2 |=> rd_data_out == two_phase_profile_out;
   endproperty
   a_rd_two: assert property (p_rd_two) else $error("two-phase read data wrong");
   property p_rd_three; clk_en_in && rd_strobe_in && hit3 |=>
      rd_data_out == three_phase_profile_out; endproperty
   a_rd_three: assert property (p_rd_three) else $error("three-phase read wrong");
   property p_rd_zero; clk_en_in && !(rd_strobe_in && (hit2 || hit3)) |=> rd_data_out == '0;
   endproperty
   a_rd_zero: assert property (p_rd_zero) else $error("read data not zero");
   property p_wr_two; clk_en_in && wr_strobe_in && hit2 |=> ##1
      two_phase_profile_out == $past(wr_data_in, 2); endproperty
   a_wr_two: assert property (p_wr_two) else $error("two-phase write lost");
   property p_wr_three; clk_en_in && wr_strobe_in && hit3 |=> ##1
      three_phase_profile_out == $past(wr_data_in, 2); endproperty
   a_wr_three: assert property (p_wr_three) else $error("three-phase write lost");
   property p_two_code; two_phase_duty_out.code == two_phase_profile_out.steps[$past(step_sel_in)];
   endproperty
   a_two_code: assert property (p_two_code) else $error("two-phase step field wrong");
   property p_three_code;
      three_phase_duty_out.code == three_phase_profile_out.steps[$past(step_sel_in)]; endproperty
   a_three_code: assert property (p_three_code) else $error("three-phase step wrong");
   property p_duty_map; two_phase_duty_out.duty == DT[two_phase_duty_out.code]; endproperty
   a_duty_map: assert property (p_duty_map) else $error("duty decode wrong");
   property p_angle; angle_advance_deg_out == three_phase_profile_out.angle_advance * 4'h5;
   endproperty
   a_angle: assert property (p_angle) else $error("angle advance wrong");

   // main scenarios reached
   c_rd_two: cover property (rd_strobe_in && hit2);
   c_wr_three: cover property (wr_strobe_in && hit3);
   c_step_last: cover property (two_phase_interval_in && step_sel_in == 3'h7);
endmodule

// [verif/mdp_profile_regs_tb.sv]
`timescale 1ns/1ps

module mdp_profile_regs_tb
   import mdp_pkg::*;
;
   logic                   clk_sys_in = 1'b0;
   logic                   reset_in = 1'b1;
   logic                   clk_en_in = 1'b1;
   logic                   wr_strobe_in = 1'b0;
   logic                   rd_strobe_in = 1'b0;
   logic                   two_phase_interval_in = 1'b0;
   logic [ADDR_W-1:0]      addr_in = '0;
   logic [DATA_W-1:0]      wr_data_in = '0;
   logic [DATA_W-1:0]      rd_data_out;
   mdp_step_type           step_sel_in = '0;
   mdp_two_profile_type    two_phase_profile_out;
   mdp_three_profile_type  three_phase_profile_out;
   mdp_duty_type           two_phase_duty_out;
   mdp_duty_type           three_phase_duty_out;
   mdp_duty_type           applied_duty_out;
   logic [ANGLE_DEG_W-1:0] angle_advance_deg_out;
   int                     error_cnt = 0;
   int                     n_checks = 0;
   localparam logic [13:0] DT [8] = '{14'h0000, 14'h1388, 14'h1D4C, 14'h20B7,
                                      14'h222E, 14'h249F, 14'h2616, 14'h26AC};

   mdp_profile_regs u_dut (.clk_sys_in, .reset_in, .clk_en_in, .addr_in, .wr_data_in,
      .wr_strobe_in, .rd_strobe_in, .rd_data_out, .two_phase_interval_in, .step_sel_in,
      .two_phase_profile_out, .three_phase_profile_out, .two_phase_duty_out,
      .three_phase_duty_out, .applied_duty_out, .angle_advance_deg_out);

   // 40 MHz clock
   initial
   begin
      forever #12.5 clk_sys_in = ~clk_sys_in;
   end

   task automatic complete_run;
      if (error_cnt == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // strobes are left up so back-to-back transfers never assign one twice per step
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      addr_in <= a;
      wr_data_in <= d;
      wr_strobe_in <= 1'b1;
      rd_strobe_in <= 1'b0;
      @(posedge clk_sys_in);
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      addr_in <= a;
      rd_strobe_in <= 1'b1;
      wr_strobe_in <= 1'b0;
      @(posedge clk_sys_in);
      #1;
      chk(rd_data_out, exp);
   endtask

   task automatic idle(input int n);
      wr_strobe_in <= 1'b0;
      rd_strobe_in <= 1'b0;
      repeat (n) @(posedge clk_sys_in);
      #1;
   endtask

   task automatic t_reset;
      rd(TWO_PH_ADDR, 32'h0000_0000);
      rd(THREE_PH_ADDR, 32'h0000_0000);
   endtask

   // every bit kept, parity and reserved included; raw offset is not a register
   task automatic t_readback;
      wr(TWO_PH_ADDR, 32'hFFFF_FFFF);
      rd(TWO_PH_ADDR, 32'hFFFF_FFFF);
      wr(THREE_PH_ADDR, 32'h8000_001F);
      rd(THREE_PH_ADDR, 32'h8000_001F);
      wr(10'h096, 32'h0000_0000);
      wr(10'h25C, 32'h0000_0000);
      rd(TWO_PH_ADDR, 32'hFFFF_FFFF);
      rd(10'h096, 32'h0000_0000);
   endtask

   // step i holds code i in the two-phase word, code 7-i in the three-phase word
   task automatic t_steps;
      logic [31:0] w2;
      logic [31:0] w3;
      logic [31:0] e2;
      logic [31:0] e3;
      w2 = '0;
      w3 = '0;
      for (int i = 0; i < 8; i++)
      begin
         w2[30-3*i -: 3] = 3'(i);
         w3[30-3*i -: 3] = 3'(7 - i);
      end
      wr(TWO_PH_ADDR, w2);
      wr(THREE_PH_ADDR, w3);
      for (int s = 0; s < 16; s++)
      begin
         two_phase_interval_in <= s[3];
         step_sel_in <= 3'(s);
         idle(2);
         // expected figures come from the step layout and the duty table only
         e2 = {15'h0, 3'(s), DT[s%8]};
         e3 = {15'h0, 3'(7-s%8), DT[7-s%8]};
         chk(32'(two_phase_duty_out), e2);
         chk(32'(three_phase_duty_out), e3);
         chk(32'(applied_duty_out), s[3] ? e2 : e3);
      end
   endtask

   task automatic t_angle;
      for (int a = 0; a < 4; a++)
      begin
         wr(THREE_PH_ADDR, {25'h0, 2'(a), 5'h0});
         idle(2);
         chk(32'(angle_advance_deg_out), 32'(5 * a));
      end
   endtask

   // reset in mid-run must clear words written earlier, the two-phase profile output and the angle output
   task automatic t_midreset;
      reset_in <= 1'b1;
      idle(2);
      reset_in <= 1'b0;
      rd(TWO_PH_ADDR, PROFILE_RESET);
      rd(THREE_PH_ADDR, PROFILE_RESET);
      chk(32'(two_phase_profile_out), PROFILE_RESET);
      chk(32'(angle_advance_deg_out), 32'h0000_0000);
   endtask

   // a write while the clock enable is low must be lost
   task automatic t_freeze;
      clk_en_in <= 1'b0;
      wr(TWO_PH_ADDR, 32'h0000_0080);
      clk_en_in <= 1'b1;
      rd(TWO_PH_ADDR, PROFILE_RESET);
   endtask

   // reset for 6 cycles, then the scenarios in turn
   initial
   begin
      repeat (6) @(posedge clk_sys_in);
      reset_in <= 1'b0;
      t_reset;
      t_readback;
      t_steps;
      t_angle;
      t_midreset;
      t_freeze;
      complete_run;
   end

   // hang guard
   initial
   begin
      repeat (5000) @(posedge clk_sys_in);
      error_cnt++;
      complete_run;
   end
endmodule

bind mdp_profile_regs mdp_profile_regs_props u_props (.clk_sys_in, .reset_in, .clk_en_in,
   .addr_in, .wr_data_in, .wr_strobe_in, .rd_strobe_in, .rd_data_out, .two_phase_interval_in,
   .step_sel_in, .two_phase_profile_out, .three_phase_profile_out, .two_phase_duty_out,
   .three_phase_duty_out, .applied_duty_out, .angle_advance_deg_out);
